//--- bridge_pkg.sv
// Shared constants, types and states of the byte-to-word bus adapter.
package bridge_pkg;

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int BYTE_W    = 8;
  localparam int WORD_W    = 16;
  localparam int BUF_DEPTH = 2;

  // ---------------------------------------------------------------
  // Byte select encodings and reset values
  // ---------------------------------------------------------------
  // The upper byte is the latched one; it moves first except in slave reads, which take the lower byte first.
  localparam logic SEL_UPPER = 1'b1;
  localparam logic SEL_LOWER = 1'b0;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0] upper;
    logic [BYTE_W-1:0] lower;
  } word_s;

  typedef struct packed {
    logic rd;
    logic byte_sel;
    logic oe;
  } narrow_ctl_s;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    idle_state,
    M_FIRST,
    M_GAP,
    M_SECOND,
    M_DONE,
    S_PTR,
    S_WUP,
    S_WLO,
    S_RLO,
    S_RWAIT,
    S_RUP
  } seq_state_e;

endpackage : bridge_pkg

//--- byte_latch.sv
// Upper data byte latch with load enable.
module byte_latch (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          nrst_in,
  // Load port
  input  wire logic                          load_in,
  input  wire logic [bridge_pkg::BYTE_W-1:0] data_in,
  // Held byte
  output logic      [bridge_pkg::BYTE_W-1:0] data_out
);

  logic [bridge_pkg::BYTE_W-1:0] hold_q;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_q <= bridge_pkg::BYTE_RST;
    end else if (load_in) begin
      hold_q <= data_in;
    end
  end

  assign data_out = hold_q;

endmodule : byte_latch

//--- word_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
module word_buffer #(
  parameter int W     = bridge_pkg::WORD_W,
  parameter int DEPTH = bridge_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  // Fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_out  = (cnt_q != DEPTH[PW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Pointers and fill count
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= (PW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= (PW+1)'(cnt_q - 1'b1);
      end
    end
  end

endmodule : word_buffer

//--- byte_to_word_bus_adapter.sv
// Sequencer joining a 16-bit bus-master display controller to an 8-bit bus.
module byte_to_word_bus_adapter (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Arbitration: high while the controller owns the bus
  input  wire logic        master_in,
  // Display controller control
  input  wire logic        address_valid_strobe_in,
  input  wire logic        transfer_strobe_in,
  output logic             transfer_strobe_out,
  output logic             transfer_strobe_oe_out,
  input  wire logic        read_write_in,
  output logic             read_write_out,
  output logic             read_write_oe_out,
  output logic             hold_out,
  // Display controller data
  input  wire logic [15:0] ctl_data_in,
  output logic      [15:0] ctl_data_out,
  output logic             ctl_data_oe_out,
  // Narrow bus control
  input  wire logic        chip_select_in,
  input  wire logic        cmd_select_in,
  input  wire logic        rd_in,
  output logic             rd_out,
  output logic             rd_oe_out,
  input  wire logic        wr_in,
  input  wire logic        byte_select_bit_in,
  output logic             byte_select_bit_out,
  output logic             byte_select_bit_oe_out,
  input  wire logic        mem_ack_in,
  // Narrow bus data
  input  wire logic [7:0]  sys_data_in,
  output logic      [7:0]  sys_data_out,
  output logic             sys_data_oe_out
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  bridge_pkg::seq_state_e  state_q;
  bridge_pkg::seq_state_e  state_d;
  bridge_pkg::narrow_ctl_s narrow;
  bridge_pkg::word_s       fill_word;
  bridge_pkg::word_s       head_word;
  logic [7:0]              upper_byte;
  logic [7:0]              latch_src;
  logic                    latch_load;
  logic                    fill_valid;
  logic                    fill_ready;
  logic                    head_valid;
  logic                    head_pop;
  logic                    cpu_act;
  logic                    cpu_act_q;
  logic                    cpu_start;
  logic                    cpu_end;
  logic                    strobe_q;
  logic                    master_start;
  logic                    slave_start;
  logic [15:0]             slv_word_q;
  logic [7:0]              sys_data_q;

  function automatic logic in_master(input bridge_pkg::seq_state_e s);
    return (s == bridge_pkg::M_FIRST) || (s == bridge_pkg::M_GAP) ||
           (s == bridge_pkg::M_SECOND) || (s == bridge_pkg::M_DONE);
  endfunction : in_master

  // ---------------------------------------------------------------
  // Start and end detection
  // ---------------------------------------------------------------
  assign cpu_act   = chip_select_in && (rd_in || wr_in);
  assign cpu_start = cpu_act && !cpu_act_q;
  assign cpu_end   = !cpu_act && cpu_act_q;

  // Only a read with address strobe opens a master sequence; a write
  // with address strobe merely loads the upper address latch.
  assign master_start = master_in && address_valid_strobe_in &&
                        read_write_in && !mem_ack_in && fill_ready;
  assign slave_start  = !master_in && cpu_start && !mem_ack_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_act_q <= 1'b0;
      strobe_q  <= 1'b0;
    end else begin
      cpu_act_q <= cpu_act;
      strobe_q  <= transfer_strobe_in;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= bridge_pkg::idle_state;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      bridge_pkg::idle_state: begin
        if (master_start) begin
          state_d = bridge_pkg::M_FIRST;
        end else if (slave_start && wr_in && cmd_select_in) begin
          state_d = bridge_pkg::S_PTR;
        end else if (slave_start && wr_in && byte_select_bit_in == bridge_pkg::SEL_UPPER) begin
          state_d = bridge_pkg::S_WUP;
        end else if (slave_start && rd_in && !cmd_select_in &&
                     byte_select_bit_in == bridge_pkg::SEL_LOWER) begin
          state_d = bridge_pkg::S_RLO;
        end
      end
      bridge_pkg::M_FIRST: begin
        if (mem_ack_in) begin
          state_d = bridge_pkg::M_GAP;
        end
      end
      bridge_pkg::M_GAP: begin
        if (!mem_ack_in) begin
          state_d = bridge_pkg::M_SECOND;
        end
      end
      bridge_pkg::M_SECOND: begin
        if (mem_ack_in && fill_ready) begin
          state_d = bridge_pkg::M_DONE;
        end
      end
      bridge_pkg::M_DONE: begin
        if (head_pop) begin
          state_d = bridge_pkg::idle_state;
        end
      end
      bridge_pkg::S_WUP: begin
        // Arbitration is not consulted here, so no master sequence can cut in.
        if (cpu_start && wr_in && !cmd_select_in &&
            byte_select_bit_in == bridge_pkg::SEL_LOWER) begin
          state_d = bridge_pkg::S_WLO;
        end
      end
      bridge_pkg::S_PTR,
      bridge_pkg::S_WLO,
      bridge_pkg::S_RUP: begin
        if (cpu_end) begin
          state_d = bridge_pkg::idle_state;
        end
      end
      bridge_pkg::S_RLO: begin
        if (cpu_end) begin
          state_d = bridge_pkg::S_RWAIT;
        end
      end
      bridge_pkg::S_RWAIT: begin
        if (cpu_start && rd_in && byte_select_bit_in == bridge_pkg::SEL_UPPER) begin
          state_d = bridge_pkg::S_RUP;
        end
      end
      default: begin
        state_d = bridge_pkg::idle_state;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Narrow bus control
  // ---------------------------------------------------------------
  // The adapter owns byte select and read only as master; it has no
  // write strobe at all.
  always_comb begin
    narrow.oe       = master_in;
    narrow.rd       = (state_q == bridge_pkg::M_FIRST) ||
                      (state_q == bridge_pkg::M_SECOND);
    narrow.byte_sel = (state_q == bridge_pkg::M_SECOND) ?
                      bridge_pkg::SEL_LOWER : bridge_pkg::SEL_UPPER;
  end

  assign rd_out                 = narrow.rd;
  assign rd_oe_out              = narrow.oe;
  assign byte_select_bit_out    = narrow.byte_sel;
  assign byte_select_bit_oe_out = narrow.oe;

  // The controller waits until a whole word is ready for it.
  assign hold_out = in_master(state_q) &&
                    !((state_q == bridge_pkg::M_DONE) && head_valid);

  // ---------------------------------------------------------------
  // Controller strobe and direction in slave accesses
  // ---------------------------------------------------------------
  // Only the lower-byte access of a word, or a pointer write, reaches the controller.
  assign transfer_strobe_oe_out = !master_in;
  assign read_write_oe_out      = !master_in;
  assign transfer_strobe_out    = (state_q == bridge_pkg::S_PTR) ||
                                  (state_q == bridge_pkg::S_WLO) ||
                                  (state_q == bridge_pkg::S_RLO);
  assign read_write_out         = (state_q == bridge_pkg::S_RLO);

  // ---------------------------------------------------------------
  // Upper byte latch
  // ---------------------------------------------------------------
  always_comb begin
    latch_src  = sys_data_in;
    latch_load = 1'b0;
    if (state_q == bridge_pkg::M_FIRST && mem_ack_in) begin
      latch_load = 1'b1;
    end else if (state_q == bridge_pkg::S_WUP && wr_in && chip_select_in &&
                 byte_select_bit_in == bridge_pkg::SEL_UPPER) begin
      latch_load = 1'b1;
    end else if (state_q == bridge_pkg::S_RLO) begin
      latch_src  = ctl_data_in[15:8];
      latch_load = 1'b1;
    end
  end

  byte_latch u_latch (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .load_in  (latch_load),
    .data_in  (latch_src),
    .data_out (upper_byte)
  );

  // ---------------------------------------------------------------
  // Master read word path
  // ---------------------------------------------------------------
  // The second byte goes straight from the bus into the buffer.
  assign fill_word.upper = upper_byte;
  assign fill_word.lower = sys_data_in;
  assign fill_valid      = (state_q == bridge_pkg::M_SECOND) && mem_ack_in;
  assign head_pop        = (state_q == bridge_pkg::M_DONE) && head_valid &&
                           strobe_q && !transfer_strobe_in;

  word_buffer u_buf (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (fill_valid),
    .in_ready_out  (fill_ready),
    .in_data_in    (fill_word),
    .out_valid_out (head_valid),
    .out_ready_in  (head_pop),
    .out_data_out  (head_word)
  );

  // ---------------------------------------------------------------
  // Slave data paths
  // ---------------------------------------------------------------
  // A pointer carries only the low byte; the upper half reads as zero.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slv_word_q <= bridge_pkg::WORD_RST;
    end else if (wr_in && chip_select_in) begin
      slv_word_q <= cmd_select_in ? {bridge_pkg::BYTE_RST, sys_data_in} :
                                    {upper_byte, sys_data_in};
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sys_data_q <= bridge_pkg::BYTE_RST;
    end else if (state_q == bridge_pkg::S_RLO) begin
      sys_data_q <= ctl_data_in[7:0];
    end else begin
      sys_data_q <= upper_byte;
    end
  end

  assign sys_data_out    = sys_data_q;
  assign sys_data_oe_out = !master_in && rd_in && chip_select_in &&
                           ((state_q == bridge_pkg::S_RLO) ||
                            (state_q == bridge_pkg::S_RUP));

  assign ctl_data_out    = in_master(state_q) ? head_word : slv_word_q;
  assign ctl_data_oe_out = ((state_q == bridge_pkg::M_DONE) && head_valid) ||
                           (state_q == bridge_pkg::S_PTR) ||
                           (state_q == bridge_pkg::S_WLO);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  first_byte_kept_a: assert property (
    (state_q == bridge_pkg::M_FIRST && mem_ack_in) |=> (upper_byte == $past(sys_data_in)))
    else $error("first fetched byte not latched");
  idle_waits_ack_a: assert property (
    (state_q == bridge_pkg::idle_state && mem_ack_in) |=> (state_q == bridge_pkg::idle_state))
    else $error("sequence started with acknowledge active");
  addr_update_a: assert property (
    (state_q == bridge_pkg::idle_state && master_in && !read_write_in)
      |=> (state_q == bridge_pkg::idle_state))
    else $error("address latch update started a sequence");
  sel_order_a: assert property (
    (state_q == bridge_pkg::M_FIRST) |-> (byte_select_bit_out == bridge_pkg::SEL_UPPER)
      ##[1:1000] (state_q == bridge_pkg::M_SECOND &&
                  byte_select_bit_out == bridge_pkg::SEL_LOWER))
    else $error("byte select order wrong in master read");
  two_reads_a: assert property (
    $rose(state_q == bridge_pkg::M_GAP) |-> $past(rd_out) && !rd_out)
    else $error("read strobe missing between byte cycles");
  hold_until_done_a: assert property (
    $fell(hold_out) && master_in |-> (state_q == bridge_pkg::M_DONE) && head_valid
      && ctl_data_oe_out)
    else $error("hold released before the word was ready");
  no_drive_master_a: assert property (
    in_master(state_q) |-> !sys_data_oe_out && !transfer_strobe_oe_out)
    else $error("adapter drove data or strobe in master read");
  strobe_once_a: assert property (
    (state_q == bridge_pkg::S_WUP) |-> !transfer_strobe_out)
    else $error("controller strobed on the latched byte");
  ptr_skip_a: assert property (
    (state_q == bridge_pkg::idle_state && slave_start && wr_in && cmd_select_in)
      |=> (state_q == bridge_pkg::S_PTR) ##1 !(state_q inside {bridge_pkg::S_WUP}))
    else $error("pointer write entered the upper byte half");
  no_break_a: assert property (
    (state_q == bridge_pkg::S_WUP) |=> !in_master(state_q))
    else $error("master sequence broke a slave word");

endmodule : byte_to_word_bus_adapter

//--- narrow_mem_model.sv
// Behavioural narrow-bus memory that answers the adapter's byte read strobes.
module narrow_mem_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Narrow bus from the adapter
  input  wire logic        rd_in,
  input  wire logic        byte_select_bit_in,
  // Test control
  input  wire logic [15:0] word_in,
  input  wire logic [3:0]  delay_in,
  input  wire logic        stuck_ack_in,
  // Answer
  output logic             mem_ack_out,
  output logic      [7:0]  data_out
);
  logic       ack_q;
  logic [3:0] wait_q;

  assign mem_ack_out = ack_q | stuck_ack_in;

  // Acknowledge after the chosen wait and hold it until the strobe drops.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q  <= 1'b0;
      wait_q <= 4'h0;
    end else if (rd_in && !ack_q) begin
      if (wait_q == delay_in) begin
        ack_q <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else if (!rd_in && ack_q) begin
      ack_q  <= 1'b0;
      wait_q <= 4'h0;
    end
  end

  // Whole aligned words only; a released bus shows a changing pattern.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= 8'h5a;
    end else if (rd_in && !ack_q && wait_q == delay_in) begin
      data_out <= (byte_select_bit_in == bridge_pkg::SEL_UPPER) ? word_in[15:8] : word_in[7:0];
    end else if (!ack_q || !rd_in) begin
      data_out <= ~data_out;
    end
  end
endmodule : narrow_mem_model

//--- byte_to_word_bus_adapter_tb.sv
// Self-checking testbench of the byte-to-word bus adapter.
module byte_to_word_bus_adapter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        master = 1'b0, avs = 1'b0, ts = 1'b0, rw = 1'b1;
  logic        cs = 1'b0, cmd = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0, sel = 1'b0;
  logic [7:0]  cpu_data = 8'h00;
  logic [15:0] ctl_in = 16'h0000, mem_word = 16'h0000;
  logic [3:0]  mem_delay = 4'h0;
  logic        stuck = 1'b0;
  logic        ts_out, ts_oe, rw_out, rw_oe, hold, ctl_oe, rd, rd_oe, sel_out, sel_oe;
  logic        ack, sys_oe, s_ts, s_rw, s_oe, s_sys_oe;
  logic [15:0] ctl_out, s_word;
  logic [7:0]  mem_data, sys_out, s_sys;
  int          fails = 0;
  int          comparisons = 0;

  always #20 mclk_in = ~mclk_in;

  byte_to_word_bus_adapter i_byte_to_word_bus_adapter (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .master_in(master),
    .address_valid_strobe_in(avs), .transfer_strobe_in(ts), .transfer_strobe_out(ts_out),
    .transfer_strobe_oe_out(ts_oe), .read_write_in(rw), .read_write_out(rw_out),
    .read_write_oe_out(rw_oe), .hold_out(hold), .ctl_data_in(ctl_in), .ctl_data_out(ctl_out),
    .ctl_data_oe_out(ctl_oe), .chip_select_in(cs), .cmd_select_in(cmd), .rd_in(cpu_rd),
    .rd_out(rd), .rd_oe_out(rd_oe), .wr_in(cpu_wr), .byte_select_bit_in(sel),
    .byte_select_bit_out(sel_out), .byte_select_bit_oe_out(sel_oe), .mem_ack_in(ack),
    .sys_data_in(master ? mem_data : cpu_data), .sys_data_out(sys_out),
    .sys_data_oe_out(sys_oe));

  narrow_mem_model i_narrow_mem_model (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .rd_in(rd & rd_oe), .byte_select_bit_in(sel_out),
    .word_in(mem_word), .delay_in(mem_delay), .stuck_ack_in(stuck), .mem_ack_out(ack),
    .data_out(mem_data));

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Word read as bus master; stuck_n cycles of a lingering acknowledge first.
  task automatic master_read(input logic [15:0] w, input logic [3:0] dly, input int stuck_n);
    int         rises;
    logic [1:0] sels;
    logic       was_rd;
    rises = 0;
    sels = 2'b00;
    was_rd = 1'b0;
    @(negedge mclk_in);
    mem_word = w;
    mem_delay = dly;
    stuck = (stuck_n > 0);
    master = 1'b1;
    rw = 1'b1;
    avs = 1'b1;
    ts = 1'b1;
    if (stuck_n > 0) begin
      repeat (stuck_n) @(negedge mclk_in);
      chk(rd === 1'b0 && hold === 1'b0, "read began under old acknowledge");
      stuck = 1'b0;
    end
    for (int n = 0; n < 200 && !(rises == 2 && hold === 1'b0 && ctl_oe === 1'b1); n++) begin
      @(negedge mclk_in);
      if (rd === 1'b1 && !was_rd) begin
        sels = {sels[0], sel_out};
        rises++;
      end
      was_rd = (rd === 1'b1);
      if (rises == 1) chk(hold === 1'b1, "hold missing mid word");
    end
    chk(rises == 2, "read strobe count");
    chk(sels === {bridge_pkg::SEL_UPPER, bridge_pkg::SEL_LOWER}, "byte select order");
    chk(ctl_out === w, "assembled word");
    chk(rd_oe === 1'b1 && sel_oe === 1'b1 && ts_oe === 1'b0, "master drive enables");
    repeat (2) @(negedge mclk_in);
    chk(ctl_out === w && hold === 1'b0, "word lost while controller stalls");
    ts = 1'b0;
    avs = 1'b0;
    repeat (3) @(negedge mclk_in);
    chk(rd === 1'b0 && hold === 1'b0, "not idle after word");
    $display("master read %h done", w);
  endtask : master_read

  // The controller only reloads its upper address latch here.
  task automatic address_update();
    @(negedge mclk_in);
    master = 1'b1;
    rw = 1'b0;
    avs = 1'b1;
    repeat (8) @(negedge mclk_in);
    chk(rd === 1'b0 && hold === 1'b0, "address update started a read");
    avs = 1'b0;
    rw = 1'b1;
    @(negedge mclk_in);
    $display("address update done");
  endtask : address_update

  task automatic cpu_access(input logic is_wr, input logic c, input logic s, input logic [7:0] d);
    @(negedge mclk_in);
    master = 1'b0;
    cs = 1'b1;
    cmd = c;
    sel = s;
    cpu_data = d;
    cpu_wr = is_wr;
    cpu_rd = !is_wr;
    repeat (3) @(negedge mclk_in);
    {s_ts, s_rw, s_oe, s_word, s_sys, s_sys_oe} = {ts_out, rw_out, ctl_oe, ctl_out, sys_out, sys_oe};
    chk(ts_oe === 1'b1 && rw_oe === 1'b1 && rd_oe === 1'b0, "slave drive enables");
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cs = 1'b0;
    repeat (3) @(negedge mclk_in);
    chk(ts_out === 1'b0, "strobe not released");
  endtask : cpu_access

  task automatic slave_tests();
    cpu_access(1'b1, 1'b0, bridge_pkg::SEL_UPPER, 8'hc3);
    chk(s_ts === 1'b0, "strobe on latched byte");
    master = 1'b1;
    avs = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk(rd === 1'b0 && hold === 1'b0, "master read broke a slave word");
    avs = 1'b0;
    cpu_access(1'b1, 1'b0, bridge_pkg::SEL_LOWER, 8'h3c);
    chk(s_ts === 1'b1 && s_rw === 1'b0 && s_oe === 1'b1, "write strobe");
    chk(s_word === 16'hc33c, "slave write word");
    cpu_access(1'b1, 1'b0, bridge_pkg::SEL_LOWER, 8'h77);
    chk(s_ts === 1'b0, "lone lower write taken");
    cpu_access(1'b1, 1'b1, bridge_pkg::SEL_LOWER, 8'h15);
    chk(s_ts === 1'b1 && s_word === 16'h0015, "pointer write");
    ctl_in = 16'ha55a;
    cpu_access(1'b0, 1'b0, bridge_pkg::SEL_LOWER, 8'h00);
    chk(s_ts === 1'b1 && s_rw === 1'b1 && s_sys === 8'h5a && s_sys_oe === 1'b1, "lower read");
    cpu_access(1'b0, 1'b0, bridge_pkg::SEL_UPPER, 8'h00);
    chk(s_ts === 1'b0 && s_sys === 8'ha5, "upper read from latch");
    $display("slave accesses done");
  endtask : slave_tests

  initial begin
    repeat (4) @(posedge mclk_in);
    @(negedge mclk_in);
    nrst_in = 1'b1;
    chk(hold === 1'b0 && rd === 1'b0 && ts_out === 1'b0, "reset state");
    master_read(16'hbe21, 4'h0, 0);
    master_read(16'h7e81, 4'h5, 0);
    master_read(16'h0ff0, 4'h1, 4);
    address_update();
    slave_tests();
    master_read(16'hffff, 4'h2, 0);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    $display("ERROR at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : byte_to_word_bus_adapter_tb
